// >>> design/cis_exec.sv
`timescale 1ns/1ps
module cis_exec
	import cis_pkg::*;
#(
	parameter logic [15:0] RESET_PC = RESET_PC_DEF,
	parameter logic [15:0] VEC_ADDR = VEC_ADDR_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	output logic      [15:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        irq_wake,
	output logic             cpu_waiting,
	output logic      [7:0]  acc_out,
	output logic      [7:0]  idx_out,
	output logic      [7:0]  cc_out,
	output logic      [15:0] pc_out,
	output logic      [7:0]  sp_out
);
	typedef enum logic [3:0] {
		S_FETCH,
		S_OPB1,
		S_OPB2,
		S_DATA,
		S_EXEC,
		S_PUSH,
		S_VECH,
		S_VECL,
		S_WAIT,
		S_PAD
	} cis_state_e;

	cis_state_e  state_q;
	cis_op_e     cls_q;
	cis_op_e     dc_cls;
	cis_mode_e   mode_q;
	cis_mode_e   dc_mode;
	logic [7:0]  op_q;
	logic [3:0]  total_q;
	logic [3:0]  dc_total;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic        fin;
	logic [15:0] pc_q;
	logic [15:0] ea_q;
	logic [7:0]  b1_q;
	logic [7:0]  a_q;
	logic [7:0]  x_q;
	logic [7:0]  sp_q;
	logic [4:0]  cc_q;
	logic [2:0]  push_q;
	logic        exec_now;
	logic [7:0]  opnd;
	logic [7:0]  alu_res;
	logic        alu_n;
	logic        alu_z;
	logic        alu_c;
	logic        take_br;

	// opcode classification from the byte on the bus during fetch
	always_comb begin
		dc_cls = OP_NOP;
		if (mem_rdata == OPC_TRAP) begin
			dc_cls = OP_TRAP;
		end else if (mem_rdata == OPC_A2X) begin
			dc_cls = OP_A2X;
		end else if (mem_rdata == OPC_X2A) begin
			dc_cls = OP_X2A;
		end else if (mem_rdata == OPC_WAIT) begin
			dc_cls = OP_WAIT;
		end else if (mem_rdata[3:0] == LO_SUB && mem_rdata[7:4] >= 4'hA) begin
			dc_cls = OP_SUB;
		end else if (mem_rdata[3:0] == LO_TEST && mem_rdata[7:4] >= 4'h3
				&& mem_rdata[7:4] <= 4'h7) begin
			dc_cls = OP_TEST;
		end else if (mem_rdata[7:4] == HI_BTB) begin
			dc_cls = OP_BTB;
		end
		dc_mode  = (dc_cls == OP_SUB || dc_cls == OP_TEST || dc_cls == OP_BTB)
			? cis_mode_of(mem_rdata[7:4]) : M_NONE;
		dc_total = cis_cycles(dc_cls, mem_rdata[7:4]);
	end

	assign cnt_d = cnt_q + 4'h1;
	assign fin   = (state_q == S_FETCH) ? (cnt_d >= dc_total) : (cnt_d >= total_q);

	// bus requests follow the state directly; memory answers in the same cycle
	always_comb begin
		mem_addr  = pc_q;
		mem_rd    = 1'b0;
		mem_wr    = 1'b0;
		mem_wdata = 8'h00;
		unique case (state_q)
			S_FETCH, S_OPB1, S_OPB2: begin
				mem_rd = 1'b1;
			end
			S_DATA: begin
				mem_addr = ea_q;
				mem_rd   = 1'b1;
			end
			S_PUSH: begin
				mem_addr = {STACK_PAGE, sp_q};
				mem_wr   = 1'b1;
				unique case (push_q)
					3'h0:    mem_wdata = pc_q[7:0];
					3'h1:    mem_wdata = pc_q[15:8];
					3'h2:    mem_wdata = x_q;
					3'h3:    mem_wdata = a_q;
					default: mem_wdata = {CC_PAD, cc_q};
				endcase
			end
			S_VECH: begin
				mem_addr = VEC_ADDR;
				mem_rd   = 1'b1;
			end
			S_VECL: begin
				mem_addr = VEC_ADDR + 16'h0001;
				mem_rd   = 1'b1;
			end
			default: begin
				mem_addr = pc_q;
			end
		endcase
	end

	// operand arrives either from the literal byte, from memory, or from A or X
	always_comb begin
		exec_now = 1'b0;
		opnd     = mem_rdata;
		if (state_q == S_OPB1 && mode_q == M_LIT) begin
			exec_now = 1'b1;
		end else if (state_q == S_DATA) begin
			exec_now = 1'b1;
		end else if (state_q == S_EXEC) begin
			exec_now = 1'b1;
			opnd     = (mode_q == M_IMPL_X) ? x_q : a_q;
		end
		take_br = opnd[op_q[3:1]] ^ op_q[0];
	end

	cis_alu u_alu (
		.acc       (a_q),
		.opnd      (opnd),
		.test_only (cls_q == OP_TEST),
		.result    (alu_res),
		.flag_n    (alu_n),
		.flag_z    (alu_z),
		.flag_c    (alu_c)
	);

	// sequencing; short instructions are padded to their documented length
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= S_FETCH;
			cnt_q   <= 4'h0;
			push_q  <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
			unique case (state_q)
				S_FETCH: begin
					unique case (dc_cls)
						OP_TRAP:        state_q <= S_PUSH;
						OP_WAIT:        state_q <= S_WAIT;
						OP_A2X, OP_X2A: state_q <= S_EXEC;
						OP_NOP:         state_q <= S_PAD;
						default: begin
							if (dc_mode == M_XNONE) begin
								state_q <= S_DATA;
							end else if (dc_mode == M_IMPL_A || dc_mode == M_IMPL_X) begin
								state_q <= S_EXEC;
							end else begin
								state_q <= S_OPB1;
							end
						end
					endcase
					push_q <= 3'h0;
				end
				S_OPB1: begin
					if (mode_q == M_LIT) begin
						state_q <= fin ? S_FETCH : S_PAD;
					end else if (mode_q == M_DIR || mode_q == M_XBYTE) begin
						state_q <= S_DATA;
					end else begin
						state_q <= S_OPB2;
					end
				end
				S_OPB2:  state_q <= S_DATA;
				S_PUSH: begin
					push_q <= push_q + 3'h1;
					if (push_q == PUSH_LAST) begin
						state_q <= S_VECH;
					end
				end
				S_VECH:  state_q <= S_VECL;
				S_WAIT: begin
					if (irq_wake) begin
						state_q <= S_FETCH;
					end
				end
				default: state_q <= fin ? S_FETCH : S_PAD;
			endcase
			if ((state_q != S_FETCH && state_q != S_OPB2 && state_q != S_PUSH
					&& state_q != S_VECH && state_q != S_WAIT
					&& !(state_q == S_OPB1 && mode_q != M_LIT) && fin)
					|| (state_q == S_WAIT && irq_wake)) begin
				cnt_q <= 4'h0;
			end
		end
	end

	// decoded instruction, program counter and effective address
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			op_q    <= 8'h00;
			cls_q   <= OP_NOP;
			mode_q  <= M_NONE;
			total_q <= CYC_NOP;
			pc_q    <= RESET_PC;
			ea_q    <= 16'h0000;
			b1_q    <= 8'h00;
		end else begin
			unique case (state_q)
				S_FETCH: begin
					op_q    <= mem_rdata;
					cls_q   <= dc_cls;
					mode_q  <= dc_mode;
					total_q <= dc_total;
					pc_q    <= pc_q + 16'h0001;
					ea_q    <= {DIRECT_PAGE, x_q};
				end
				S_OPB1: begin
					b1_q <= mem_rdata;
					pc_q <= pc_q + 16'h0001;
					if (mode_q == M_XBYTE) begin
						ea_q <= {8'h00, x_q} + {8'h00, mem_rdata};
					end else begin
						ea_q <= {DIRECT_PAGE, mem_rdata};
					end
				end
				S_OPB2: begin
					pc_q <= pc_q + 16'h0001;
					if (mode_q == M_XWORD) begin
						ea_q <= {b1_q, mem_rdata} + {8'h00, x_q};
					end else if (mode_q == M_FULL) begin
						ea_q <= {b1_q, mem_rdata};
					end else begin
						ea_q <= {DIRECT_PAGE, b1_q};
						b1_q <= mem_rdata;
					end
				end
				S_DATA: begin
					if (cls_q == OP_BTB && take_br) begin
						pc_q <= pc_q + {{8{b1_q[7]}}, b1_q};
					end
				end
				S_VECH:  pc_q[15:8] <= mem_rdata;
				S_VECL:  pc_q[7:0]  <= mem_rdata;
				default: pc_q <= pc_q;
			endcase
		end
	end

	// accumulator, index, stack pointer and condition codes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			a_q  <= ACC_RESET;
			x_q  <= IDX_RESET;
			sp_q <= SP_RESET;
			cc_q <= CC_RESET;
		end else begin
			if (state_q == S_FETCH && dc_cls == OP_WAIT) begin
				cc_q[CC_I] <= 1'b0;
			end
			if (state_q == S_PUSH) begin
				sp_q <= sp_q - 8'h01;
				if (push_q == PUSH_LAST) begin
					cc_q[CC_I] <= 1'b1;
				end
			end
			if (exec_now) begin
				unique case (cls_q)
					OP_SUB: begin
						a_q        <= alu_res;
						cc_q[CC_N] <= alu_n;
						cc_q[CC_Z] <= alu_z;
						cc_q[CC_C] <= alu_c;
					end
					OP_TEST: begin
						cc_q[CC_N] <= alu_n;
						cc_q[CC_Z] <= alu_z;
					end
					OP_A2X:  x_q <= a_q;
					OP_X2A:  a_q <= x_q;
					OP_BTB:  cc_q[CC_C] <= opnd[op_q[3:1]];
					default: a_q <= a_q;
				endcase
			end
		end
	end

	assign cpu_waiting = (state_q == S_WAIT);
	assign acc_out     = a_q;
	assign idx_out     = x_q;
	assign cc_out      = {CC_PAD, cc_q};
	assign pc_out      = pc_q;
	assign sp_out      = sp_q;
endmodule // cis_exec

// >>> design/cis_pkg.sv
package cis_pkg;

	localparam logic [15:0] RESET_PC_DEF = 16'h0000;
	localparam logic [15:0] VEC_ADDR_DEF = 16'hFFFC;
	localparam logic [7:0]  SP_RESET     = 8'hFF;
	localparam logic [7:0]  ACC_RESET    = 8'h00;
	localparam logic [7:0]  IDX_RESET    = 8'h00;
	localparam logic [7:0]  STACK_PAGE   = 8'h00;
	localparam logic [7:0]  DIRECT_PAGE  = 8'h00;

	// condition code bit positions; the upper three bits stack as ones
	localparam int CC_H = 4;
	localparam int CC_I = 3;
	localparam int CC_N = 2;
	localparam int CC_Z = 1;
	localparam int CC_C = 0;
	localparam logic [4:0] CC_RESET = 5'h08;
	localparam logic [2:0] CC_PAD   = 3'h7;

	localparam logic [7:0] OPC_TRAP = 8'h83;
	localparam logic [7:0] OPC_A2X  = 8'h97;
	localparam logic [7:0] OPC_X2A  = 8'h9F;
	localparam logic [7:0] OPC_WAIT = 8'h8F;
	localparam logic [3:0] LO_SUB   = 4'h0;
	localparam logic [3:0] LO_TEST  = 4'hD;
	localparam logic [3:0] HI_BTB   = 4'h0;

	localparam logic [3:0] CYC_TRAP = 4'hA;
	localparam logic [3:0] CYC_XFER = 4'h2;
	localparam logic [3:0] CYC_WAIT = 4'h2;
	localparam logic [3:0] CYC_BTB  = 4'h5;
	localparam logic [3:0] CYC_NOP  = 4'h2;
	localparam logic [2:0] PUSH_LAST = 3'h4;

	typedef enum logic [3:0] {
		M_NONE,
		M_IMPL_A,
		M_IMPL_X,
		M_LIT,
		M_DIR,
		M_FULL,
		M_XWORD,
		M_XBYTE,
		M_XNONE,
		M_BTB
	} cis_mode_e;

	typedef enum logic [2:0] {
		OP_NOP,
		OP_SUB,
		OP_TEST,
		OP_A2X,
		OP_X2A,
		OP_TRAP,
		OP_WAIT,
		OP_BTB
	} cis_op_e;

	function automatic cis_mode_e cis_mode_of(input logic [3:0] hi);
		unique case (hi)
			4'h0:       return M_BTB;
			4'h3, 4'hB: return M_DIR;
			4'h4:       return M_IMPL_A;
			4'h5:       return M_IMPL_X;
			4'h6, 4'hE: return M_XBYTE;
			4'h7, 4'hF: return M_XNONE;
			4'hA:       return M_LIT;
			4'hC:       return M_FULL;
			4'hD:       return M_XWORD;
			default:    return M_NONE;
		endcase
	endfunction

	// total cycles of an instruction, opcode fetch included
	function automatic logic [3:0] cis_cycles(input cis_op_e cls, input logic [3:0] hi);
		unique case (cls)
			OP_SUB: begin
				unique case (hi)
					4'hA:    return 4'h2;
					4'hB:    return 4'h3;
					4'hC:    return 4'h4;
					4'hD:    return 4'h5;
					4'hE:    return 4'h4;
					default: return 4'h3;
				endcase
			end
			OP_TEST: begin
				unique case (hi)
					4'h3:    return 4'h4;
					4'h6:    return 4'h5;
					4'h7:    return 4'h4;
					default: return 4'h3;
				endcase
			end
			OP_A2X, OP_X2A: return CYC_XFER;
			OP_TRAP:        return CYC_TRAP;
			OP_WAIT:        return CYC_WAIT;
			OP_BTB:         return CYC_BTB;
			default:        return CYC_NOP;
		endcase
	endfunction

endpackage

// >>> design/cis_alu.sv
`timescale 1ns/1ps
module cis_alu
	import cis_pkg::*;
(
	input  wire logic [7:0] acc,
	input  wire logic [7:0] opnd,
	input  wire logic       test_only,
	output logic      [7:0] result,
	output logic            flag_n,
	output logic            flag_z,
	output logic            flag_c
);
	logic [8:0] diff;

	// test subtracts zero from the operand; subtract takes operand from accumulator
	always_comb begin
		if (test_only) begin
			diff = {1'b0, opnd} - 9'h000;
		end else begin
			diff = {1'b0, acc} - {1'b0, opnd};
		end
		result = diff[7:0];
		flag_n = diff[7];
		flag_z = (diff[7:0] == 8'h00);
		flag_c = diff[8];
	end
endmodule // cis_alu

// >>> testbench/cis_exec_monitor.sv
`timescale 1ns/1ps
module cis_exec_monitor
	import cis_pkg::*;
#(
	parameter logic [15:0] VEC_ADDR = VEC_ADDR_DEF
) (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        irq_wake,
	input wire logic        cpu_waiting,
	input wire logic [7:0]  acc_out,
	input wire logic [7:0]  idx_out,
	input wire logic [7:0]  cc_out,
	input wire logic [15:0] pc_out,
	input wire logic [7:0]  sp_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence pushes_s;
		mem_wr && mem_wdata == pc_out[7:0] ##1 mem_wr && mem_wdata == pc_out[15:8]
		##1 mem_wr && mem_wdata == idx_out ##1 mem_wr && mem_wdata == acc_out
		##1 mem_wr && mem_wdata == cc_out;
	endsequence
	sequence vector_s;
		mem_rd && mem_addr == VEC_ADDR ##1 mem_rd && mem_addr == VEC_ADDR + 16'h0001;
	endsequence
	trap_order_a: assert property ($rose(mem_wr) |-> pushes_s)
		else $error("trap push order broken");
	trap_vector_a: assert property ($rose(mem_wr) |-> ##5 (cc_out[CC_I] and vector_s))
		else $error("trap vector fetch broken");
	push_addr_a: assert property (mem_wr |-> mem_addr == {STACK_PAGE, sp_out})
		else $error("push not at stack pointer");
	sp_step_a: assert property (mem_wr |=> sp_out == $past(sp_out) - 8'h01)
		else $error("stack pointer did not drop");
	wait_hold_a: assert property (cpu_waiting && !irq_wake |=> cpu_waiting)
		else $error("wait left without wake");
	wait_exit_a: assert property (cpu_waiting && irq_wake |=>
		!cpu_waiting && mem_rd && mem_addr == pc_out)
		else $error("wait exit not a fetch");
	wait_mask_a: assert property (cpu_waiting |->
		!cc_out[CC_I] && !mem_rd && !mem_wr)
		else $error("busy while waiting");
	// the pc steps past the wait opcode on entry, so stability is checked from the second cycle
	wait_pc_a: assert property (cpu_waiting && $past(cpu_waiting) |-> $stable(pc_out))
		else $error("program counter moved while waiting");
	idx_flags_a: assert property ($changed(idx_out) |-> $stable(cc_out))
		else $error("index move touched the flags");
	cc_pad_a: assert property (cc_out[7:5] == CC_PAD)
		else $error("condition code pad bits wrong");
endmodule // cis_exec_monitor

bind cis_exec cis_exec_monitor #(.VEC_ADDR(VEC_ADDR)) u_mon (.clk_sys(clk_sys), .rst(rst),
	.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
	.irq_wake(irq_wake), .cpu_waiting(cpu_waiting), .acc_out(acc_out), .idx_out(idx_out),
	.cc_out(cc_out), .pc_out(pc_out), .sp_out(sp_out));

// >>> testbench/cis_mem_model.sv
`timescale 1ns/1ps
module cis_mem_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q = 8'h00;
	// zero-wait answer; an idle bus shows the inverse of the last byte
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
	always @(posedge clk_sys) begin
		if (mem_rd) last_q <= mem[mem_addr];
		if (mem_wr) mem[mem_addr] <= mem_wdata;
	end
endmodule // cis_mem_model

// >>> testbench/cpu_insn_subset_exec_tb.sv
`timescale 1ns/1ps
module cpu_insn_subset_exec_tb;
	import cis_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        irq_wake = 1'b0;
	logic [15:0] mem_addr;
	logic        mem_rd;
	logic        mem_wr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic        cpu_waiting;
	logic [7:0]  acc_out;
	logic [7:0]  idx_out;
	logic [7:0]  cc_out;
	logic [15:0] pc_out;
	logic [7:0]  sp_out;
	int          miscompares = 0;
	int          compares = 0;
	always #5 clk_sys = ~clk_sys;
	cis_exec dut (.clk_sys(clk_sys), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_wake(irq_wake),
		.cpu_waiting(cpu_waiting), .acc_out(acc_out), .idx_out(idx_out), .cc_out(cc_out),
		.pc_out(pc_out), .sp_out(sp_out));
	cis_mem_model u_mem (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// waits for the opcode fetch at a and checks the cycles since the last one
	task automatic step(input logic [15:0] a, input int cyc);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (!(mem_rd === 1'b1 && mem_addr === a) && n < 60);
		if (n >= 60) begin
			miscompares++;
			$display("wrong value fetch address expected %h seen none", a);
			finish_test();
		end else if (cyc > 0) begin
			chk("cycles", cyc[15:0], n[15:0]);
		end
	endtask
	task automatic ld(input logic [15:0] a, input logic [63:0] b, input int n);
		for (int i = 0; i < n; i++) u_mem.mem[a + i[15:0]] = b[8 * (n - 1 - i) +: 8];
	endtask
	task automatic sc_reset();
		repeat (6) @(posedge clk_sys);
		#1;
		chk("pc", RESET_PC_DEF, pc_out);
		chk("sp", {8'h00, SP_RESET}, {8'h00, sp_out});
		chk("cc", 16'h00E8, {8'h00, cc_out});
		chk("fetch", 16'h0001, {15'h0000, mem_rd});
		rst = 1'b0;
		$display("test reset done");
	endtask
	task automatic sc_sub_xfer();
		step(16'h0002, 2);
		chk("acc", 16'h00FB, {8'h00, acc_out});
		chk("cc", 16'h00ED, {8'h00, cc_out});
		step(16'h0003, 2);
		chk("idx", 16'h00FB, {8'h00, idx_out});
		chk("cc", 16'h00ED, {8'h00, cc_out});
		$display("test sub_xfer done");
	endtask
	task automatic sc_modes();
		step(16'h0006, 4);
		chk("cc", 16'h00EA, {8'h00, cc_out});
		step(16'h0007, 2);
		chk("acc", 16'h00FB, {8'h00, acc_out});
		chk("cc", 16'h00EA, {8'h00, cc_out});
		step(16'h0009, 5);
		chk("cc", 16'h00EC, {8'h00, cc_out});
		step(16'h000C, 5);
		chk("acc", 16'h0001, {8'h00, acc_out});
		$display("test modes done");
	endtask
	task automatic sc_wait();
		repeat (4) @(posedge clk_sys);
		#1;
		chk("waiting", 16'h0001, {15'h0000, cpu_waiting});
		chk("cc", 16'h00E0, {8'h00, cc_out});
		irq_wake = 1'b1;
		step(16'h000D, 0);
		irq_wake = 1'b0;
		chk("waiting", 16'h0000, {15'h0000, cpu_waiting});
		$display("test wait done");
	endtask
	task automatic sc_trap();
		logic [7:0] e [5] = '{8'h0E, 8'h00, 8'hFB, 8'h01, 8'hE0};
		step(16'h0200, 10);
		chk("sp", 16'h00FA, {8'h00, sp_out});
		chk("cc", 16'h00E8, {8'h00, cc_out});
		for (int i = 0; i < 5; i++) chk("stack", e[i], u_mem.mem[16'h00FF - i[15:0]]);
		$display("test trap done");
	endtask
	task automatic sc_branch();
		step(16'h0206, 5);
		chk("cc", 16'h00E9, {8'h00, cc_out});
		$display("test branch done");
	endtask
	// unknown opcode, then the modes the earlier scenarios leave out, except implied A
	task automatic sc_more_modes();
		step(16'h0207, 2);
		step(16'h0208, 3);
		chk("cc", 16'h00ED, {8'h00, cc_out});
		step(16'h020A, 3);
		chk("acc", 16'h0000, {8'h00, acc_out});
		chk("cc", 16'h00EA, {8'h00, cc_out});
		step(16'h020B, 4);
		chk("cc", 16'h00EC, {8'h00, cc_out});
		step(16'h020C, 3);
		chk("acc", 16'h0020, {8'h00, acc_out});
		chk("cc", 16'h00E9, {8'h00, cc_out});
		step(16'h020E, 4);
		chk("cc", 16'h00EB, {8'h00, cc_out});
		step(16'h0211, 5);
		chk("cc", 16'h00EB, {8'h00, cc_out});
		step(16'h0213, 4);
		chk("acc", 16'h0025, {8'h00, acc_out});
		chk("cc", 16'h00E9, {8'h00, cc_out});
		$display("test more_modes done");
	endtask
	initial begin
		ld(16'h0000, 64'hA005_97C0_0100_9F6D, 8);
		ld(16'h0008, 64'h10D0_0100_8F83, 6);
		ld(16'h0200, 64'h0010_03, 3);
		ld(16'hFFFC, 64'h0200, 2);
		u_mem.mem[16'h0100] = 8'hFB;
		u_mem.mem[16'h010B] = 8'h80;
		u_mem.mem[16'h01FB] = 8'hFA;
		u_mem.mem[16'h0010] = 8'h01;
		ld(16'h0206, 64'h9D5D_B020_7DF0_3D21, 8);
		ld(16'h020E, 64'h0110_05E0_059D, 6);
		u_mem.mem[16'h0020] = 8'h01;
		u_mem.mem[16'h0021] = 8'h00;
		sc_reset();
		sc_sub_xfer();
		sc_modes();
		sc_wait();
		sc_trap();
		sc_branch();
		sc_more_modes();
		finish_test();
	end
endmodule // cpu_insn_subset_exec_tb
